// file: rtl/ddr2_cfg_pkg.sv
// Shared constants, types and ECC functions for the DDR2 read port
package ddr2_cfg_pkg;
    // ==========================================================
    // Latency, geometry and limits
    localparam int READ_LAT_BASE = 3;
    localparam int ECC_EXTRA_LAT = 3;
    localparam int ECC_DATA_BITS = 64;
    localparam int ECC_CHECK_BITS = 8;
    localparam int ECC_DEVICES = 8;
    localparam int ECC_DQS_PER_DEV = 1;
    localparam int MAX_PORTS = 10;
    localparam int FIFO_DEPTH_DEF = 8;
    localparam int CLOCK_PAIRS_DEF = 3;
    localparam int EMR_DRIVE_BIT = 1;
    localparam int EMR_RTT_LO_BIT = 2;
    localparam int EMR_RTT_HI_BIT = 6;

    // ==========================================================
    // Error status codes and enumerations
    localparam logic [1:0] ERR_NONE = 2'h0;
    localparam logic [1:0] ERR_FIXED = 2'h1;
    localparam logic [1:0] ERR_FATAL = 2'h2;
    typedef enum logic [1:0] {
        ODT_OFF = 2'h0,
        ODT_75 = 2'h1,
        ODT_150 = 2'h2,
        ODT_50 = 2'h3
    } odt_type;
    typedef enum logic [1:0] {
        LINK_IDLE = 2'h0,
        LINK_ACT = 2'h1,
        LINK_RD = 2'h2,
        LINK_WAIT = 2'h3
    } link_state_type;

    // ==========================================================
    // Hamming check word: bits 0..6 positional parity, bit 7 overall
    function automatic logic [7:0] ecc_check(input logic [63:0] d);
        logic [7:0] c;
        int k;
        c = 8'h00;
        k = 0;
        for (int p = 1; p < 72; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                for (int j = 0; j < 7; j++)
                begin
                    if (p[j])
                        c[j] = c[j] ^ d[k];
                end
                k++;
            end
        end
        c[7] = ^{d, c[6:0]};
        return c;
    endfunction

    // Correct one bit, flag two; returns {status, data}
    function automatic logic [67:0] ecc_fix(input logic [63:0] d,
                                            input logic [7:0] chk);
        logic [7:0] calc;
        logic [6:0] syn;
        logic odd;
        logic [3:0] st;
        logic [63:0] o;
        int k;
        calc = ecc_check(d);
        syn = calc[6:0] ^ chk[6:0];
        odd = ^{d, chk};
        o = d;
        k = 0;
        st = {ERR_NONE, ERR_NONE};
        if (odd && syn > 7'h47)
            st = {ERR_FATAL, ERR_FATAL};
        else if (odd)
            st = {ERR_NONE, ERR_FIXED};
        else if (syn != 7'h00)
            st = {ERR_FATAL, ERR_FATAL};
        for (int p = 1; p < 72; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                if (odd && syn == 7'(p))
                begin
                    o[k] = ~o[k];
                    st = (k >= 32) ? {ERR_FIXED, ERR_NONE}
                                   : {ERR_NONE, ERR_FIXED};
                end
                k++;
            end
        end
        return {st, o};
    endfunction
endpackage

// file: rtl/word_fifo_if.sv
// Handshake bundle between the read port and its word FIFO
interface word_fifo_if #(parameter int WIDTH = 72, parameter int LEVEL_W = 4);
    logic [WIDTH-1:0] in_data;
    logic in_valid;
    logic in_ready;
    logic flush;
    logic [WIDTH-1:0] out_data;
    logic out_valid;
    logic out_ready;
    logic [LEVEL_W-1:0] level;
    modport fifo (input in_data, in_valid, flush, out_ready,
                  output in_ready, out_data, out_valid, level);
    modport user (output in_data, in_valid, flush, out_ready,
                  input in_ready, out_data, out_valid, level);
endinterface

// file: rtl/word_fifo.sv
// Flip-flop word FIFO with valid/ready on both sides and a flush
module word_fifo #(
    parameter int WIDTH = 72,
    parameter int DEPTH = 8
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill and drain sides
    word_fifo_if.fifo port
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] wr_d;
    logic [AW-1:0] rd_q;
    logic [AW-1:0] rd_d;
    logic [LW-1:0] cnt_q;
    logic [LW-1:0] cnt_d;
    logic push;
    logic pop;

    // Honest full and empty
    assign port.in_ready = (cnt_q != LW'(DEPTH));
    assign port.out_valid = (cnt_q != '0);
    assign port.out_data = mem_q[rd_q];
    assign port.level = cnt_q;

    // Next pointers, count and storage
    always_comb
    begin
        push = port.in_valid && port.in_ready;
        pop = port.out_ready && port.out_valid;
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (port.flush)
        begin
            wr_d = '0;
            rd_d = '0;
            cnt_d = '0;
        end
        else
        begin
            if (push)
            begin
                mem_d[wr_q] = port.in_data;
                wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop)
                rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            cnt_d = cnt_q + LW'(push) - LW'(pop);
        end
    end

    // Register state
    always_ff @(posedge clk)
    begin
        mem_q <= mem_d;
        if (rst)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule // word_fifo

// file: rtl/ddr2_read_port.sv
// DDR2 streaming read port with optional SEC-DED ECC and memory link
module ddr2_read_port #(
    parameter int DATA_WIDTH = 64,
    parameter int BANK_BITS = 3,
    parameter int ROW_BITS = 14,
    parameter int COL_BITS = 10,
    parameter int CLOCK_PAIRS = ddr2_cfg_pkg::CLOCK_PAIRS_DEF,
    parameter int FIFO_DEPTH = ddr2_cfg_pkg::FIFO_DEPTH_DEF,
    parameter int DEVICES = 8,
    parameter int DQS_PER_DEVICE = 1,
    parameter bit ECC_ENABLE = 1'b1,
    parameter bit ECC_DIMM = 1'b1,
    parameter int PORT_COUNT = 1,
    parameter bit PORT_IS_WRITE = 1'b0,
    localparam int AW = BANK_BITS + ROW_BITS + COL_BITS,
    localparam int FW = DATA_WIDTH + ddr2_cfg_pkg::ECC_CHECK_BITS
)
(
    // Clocks and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic mem_half_rate_clock,
    // Local read side
    input wire logic init,
    input wire logic [AW-1:0] start_addr,
    input wire logic read_request,
    output logic [DATA_WIDTH-1:0] read_data,
    output logic read_data_valid,
    output logic [3:0] ecc_status,
    output logic busy,
    output logic underrun,
    // Check word generation for write data
    input wire logic [DATA_WIDTH-1:0] wr_word,
    output logic [7:0] wr_check,
    // Memory options
    input wire logic reduced_drive,
    input wire logic odt_enable,
    input wire logic [1:0] odt_sel,
    output logic [ROW_BITS-1:0] ext_mode_word,
    // Memory link
    output logic mem_cs_n,
    output logic mem_ras_n,
    output logic mem_cas_n,
    output logic mem_we_n,
    output logic [BANK_BITS-1:0] mem_ba,
    output logic [ROW_BITS-1:0] mem_addr,
    output logic mem_odt,
    output logic [CLOCK_PAIRS-1:0] mem_clk_p,
    output logic [CLOCK_PAIRS-1:0] mem_clk_n,
    input wire logic [FW-1:0] mem_rd_word,
    input wire logic mem_rd_valid,
    output logic capture_ready
);
    // ==========================================================
    // Configuration
    localparam bit ECC_ON = ECC_ENABLE && ECC_DIMM
        && DATA_WIDTH == ddr2_cfg_pkg::ECC_DATA_BITS
        && DEVICES == ddr2_cfg_pkg::ECC_DEVICES
        && DQS_PER_DEVICE == ddr2_cfg_pkg::ECC_DQS_PER_DEV;
    localparam int LAT = ddr2_cfg_pkg::READ_LAT_BASE
        + (ECC_ON ? ddr2_cfg_pkg::ECC_EXTRA_LAT : 0);
    localparam bit RD_EN = PORT_COUNT >= 1 && !PORT_IS_WRITE
        && PORT_COUNT <= ddr2_cfg_pkg::MAX_PORTS;
    localparam int HALF = FIFO_DEPTH / 2;
    localparam int LW = $clog2(FIFO_DEPTH + 1);
    localparam int HW = $clog2(HALF + 1);

    word_fifo_if #(.WIDTH(FW), .LEVEL_W(LW)) fq ();

    // Word buffer between link and local side
    word_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(ref_clk),
        .rst(rst),
        .port(fq.fifo)
    );

    // ==========================================================
    // Link-side state
    ddr2_cfg_pkg::link_state_type state_q, state_d;
    logic lrst_m_q, lrst_q;
    logic ftog_m_q, ftog_s_q, fseen_q, fseen_d;
    logic ack_m_q, ack_s_q;
    logic odt_m_q, odt_s_q;
    logic [FW-1:0] word_q, word_d;
    logic wtog_q, wtog_d;
    logic [HW-1:0] burst_q, burst_d;
    logic cs_q, cs_d, ras_q, ras_d, cas_q, cas_d;
    logic [BANK_BITS-1:0] ba_q, ba_d;
    logic [ROW_BITS-1:0] ma_q, ma_d;
    logic modt_q, modt_d;
    logic ck_q;
    logic fetch_evt, pend;

    // ==========================================================
    // Local-side state
    logic wtog_m_q, wtog_s_q, ack_q, ack_d;
    logic ftog_q, ftog_d;
    logic [AW-1:0] faddr_q, faddr_d, addr_q, addr_d;
    logic init_prev_q, active_q, active_d;
    logic [HW-1:0] expect_q, expect_d;
    logic busy_q, busy_d, under_q, under_d;
    logic [ROW_BITS-1:0] emr_q, emr_d;
    logic [7:0] chk_q, chk_d;
    logic init_rise, word_evt, want;
    logic pv_q [LAT];
    logic pv_d [LAT];
    logic [DATA_WIDTH-1:0] pd_q [LAT];
    logic [DATA_WIDTH-1:0] pd_d [LAT];
    logic [3:0] ps_q [LAT];
    logic [3:0] ps_d [LAT];
    logic [DATA_WIDTH-1:0] dec_data;
    logic [3:0] dec_st;

    // ==========================================================
    // Decode of the word leaving the FIFO
    if (ECC_ON)
    begin : g_ecc
        logic [67:0] fix;
        assign fix = ddr2_cfg_pkg::ecc_fix(fq.out_data[63:0],
                                          fq.out_data[71:64]);
        assign dec_data = fix[63:0];
        assign dec_st = fix[67:64];
    end
    else
    begin : g_plain
        assign dec_data = fq.out_data[DATA_WIDTH-1:0];
        assign dec_st = 4'h0;
    end

    // ==========================================================
    // Local control: init, fetch requests, busy, underrun, options
    always_comb
    begin
        init_rise = init && !init_prev_q;
        word_evt = wtog_s_q ^ ack_q;
        want = (expect_q != '0) && !init_rise;
        fq.in_valid = word_evt && want;
        fq.in_data = word_q;
        fq.flush = init_rise;
        fq.out_ready = read_request && RD_EN;
        ack_d = ack_q;
        if (word_evt && (fq.in_ready || !want))
            ack_d = wtog_s_q;
        expect_d = expect_q;
        if (init_rise)
            expect_d = '0;
        else if (fq.in_valid && fq.in_ready)
            expect_d = expect_q - 1'b1;
        active_d = active_q || (init_rise && RD_EN);
        addr_d = init_rise ? start_addr : addr_q;
        ftog_d = ftog_q;
        faddr_d = faddr_q;
        if (active_q && !init_rise && expect_q == '0
            && fq.level <= LW'(FIFO_DEPTH - HALF))
        begin
            ftog_d = ~ftog_q;
            faddr_d = addr_q;
            addr_d = addr_q + AW'(HALF);
            expect_d = HW'(HALF);
        end
        if (init_rise)
            busy_d = 1'b1;
        else if (busy_q)
            busy_d = fq.level < LW'(HALF);
        else
            busy_d = active_q && !fq.out_valid;
        under_d = (read_request && RD_EN && !fq.out_valid)
            || (under_q && !init_rise);
        emr_d = '0;
        emr_d[ddr2_cfg_pkg::EMR_DRIVE_BIT] = reduced_drive;
        emr_d[ddr2_cfg_pkg::EMR_RTT_LO_BIT] = odt_enable && odt_sel[0];
        emr_d[ddr2_cfg_pkg::EMR_RTT_HI_BIT] = odt_enable && odt_sel[1];
        chk_d = ECC_ON ? ddr2_cfg_pkg::ecc_check(64'(wr_word))
                       : 8'h00;
    end

    // Register local control
    always_ff @(posedge ref_clk)
    begin
        wtog_m_q <= wtog_q;
        wtog_s_q <= wtog_m_q;
        faddr_q <= faddr_d;
        if (rst)
        begin
            ack_q <= 1'b0;
            ftog_q <= 1'b0;
            addr_q <= '0;
            init_prev_q <= 1'b0;
            active_q <= 1'b0;
            expect_q <= '0;
            busy_q <= 1'b0;
            under_q <= 1'b0;
            emr_q <= '0;
            chk_q <= 8'h00;
        end
        else
        begin
            ack_q <= ack_d;
            ftog_q <= ftog_d;
            addr_q <= addr_d;
            init_prev_q <= init;
            active_q <= active_d;
            expect_q <= expect_d;
            busy_q <= busy_d;
            under_q <= under_d;
            emr_q <= emr_d;
            chk_q <= chk_d;
        end
    end

    // ==========================================================
    // Read pipeline: valid mirrors request after LAT cycles
    always_comb
    begin
        pv_d[0] = read_request && RD_EN;
        pd_d[0] = dec_data;
        ps_d[0] = dec_st;
        for (int i = 1; i < LAT; i++)
        begin
            pv_d[i] = pv_q[i-1];
            pd_d[i] = pd_q[i-1];
            ps_d[i] = ps_q[i-1];
        end
    end

    // Register read pipeline
    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < LAT; i++)
        begin
            pd_q[i] <= pd_d[i];
            ps_q[i] <= rst ? 4'h0 : ps_d[i];
            pv_q[i] <= rst ? 1'b0 : pv_d[i];
        end
    end

    assign read_data = pd_q[LAT-1];
    assign read_data_valid = pv_q[LAT-1];
    assign ecc_status = ps_q[LAT-1];
    assign busy = busy_q;
    assign underrun = under_q;
    assign wr_check = chk_q;
    assign ext_mode_word = emr_q;

    // ==========================================================
    // Link FSM: activate, read, then capture half a FIFO of words
    always_comb
    begin
        fetch_evt = ftog_s_q ^ fseen_q;
        pend = wtog_q ^ ack_s_q;
        capture_ready = (state_q == ddr2_cfg_pkg::LINK_WAIT) && !pend;
        state_d = state_q;
        fseen_d = fseen_q;
        word_d = word_q;
        wtog_d = wtog_q;
        burst_d = burst_q;
        cs_d = 1'b1;
        ras_d = 1'b1;
        cas_d = 1'b1;
        ba_d = ba_q;
        ma_d = ma_q;
        case (state_q)
            ddr2_cfg_pkg::LINK_IDLE:
                if (fetch_evt)
                begin
                    fseen_d = ftog_s_q;
                    state_d = ddr2_cfg_pkg::LINK_ACT;
                end
            ddr2_cfg_pkg::LINK_ACT:
            begin
                cs_d = 1'b0;
                ras_d = 1'b0;
                ba_d = faddr_q[AW-1 -: BANK_BITS];
                ma_d = faddr_q[COL_BITS +: ROW_BITS];
                state_d = ddr2_cfg_pkg::LINK_RD;
            end
            ddr2_cfg_pkg::LINK_RD:
            begin
                cs_d = 1'b0;
                cas_d = 1'b0;
                ma_d = ROW_BITS'(faddr_q[COL_BITS-1:0]);
                burst_d = HW'(HALF);
                state_d = ddr2_cfg_pkg::LINK_WAIT;
            end
            default:
                if (mem_rd_valid && capture_ready)
                begin
                    word_d = mem_rd_word;
                    wtog_d = ~wtog_q;
                    burst_d = burst_q - 1'b1;
                    if (burst_q == HW'(1))
                        state_d = ddr2_cfg_pkg::LINK_IDLE;
                end
        endcase
        modt_d = odt_s_q && state_d == ddr2_cfg_pkg::LINK_IDLE;
    end

    // Register link logic on the link clock
    always_ff @(posedge mem_half_rate_clock)
    begin
        lrst_m_q <= rst;
        lrst_q <= lrst_m_q;
        ftog_m_q <= ftog_q;
        ftog_s_q <= ftog_m_q;
        ack_m_q <= ack_q;
        ack_s_q <= ack_m_q;
        odt_m_q <= odt_enable;
        odt_s_q <= odt_m_q;
        word_q <= word_d;
        if (lrst_q)
        begin
            state_q <= ddr2_cfg_pkg::LINK_IDLE;
            fseen_q <= 1'b0;
            wtog_q <= 1'b0;
            burst_q <= '0;
            cs_q <= 1'b1;
            ras_q <= 1'b1;
            cas_q <= 1'b1;
            ba_q <= '0;
            ma_q <= '0;
            modt_q <= 1'b0;
            ck_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            fseen_q <= fseen_d;
            wtog_q <= wtog_d;
            burst_q <= burst_d;
            cs_q <= cs_d;
            ras_q <= ras_d;
            cas_q <= cas_d;
            ba_q <= ba_d;
            ma_q <= ma_d;
            modt_q <= modt_d;
            ck_q <= ~ck_q;
        end
    end

    // Memory pins
    assign mem_cs_n = cs_q;
    assign mem_ras_n = ras_q;
    assign mem_cas_n = cas_q;
    assign mem_we_n = 1'b1;
    assign mem_ba = ba_q;
    assign mem_addr = ma_q;
    assign mem_odt = modt_q;
    assign mem_clk_p = {CLOCK_PAIRS{ck_q}};
    assign mem_clk_n = {CLOCK_PAIRS{~ck_q}};
endmodule // ddr2_read_port

// file: tb/ddr2_read_port_chk.sv
// Pin-level assertions for the DDR2 read port
module ddr2_read_port_chk #(
    parameter int DATA_WIDTH = 64,
    parameter int ROW_BITS = 14,
    parameter int CLOCK_PAIRS = 3,
    parameter bit ECC_ENABLE = 1'b1
)
(
    // Clocks and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic mem_half_rate_clock,
    // Local side
    input wire logic init,
    input wire logic read_request,
    input wire logic read_data_valid,
    input wire logic [3:0] ecc_status,
    input wire logic busy,
    input wire logic [DATA_WIDTH-1:0] wr_word,
    input wire logic [7:0] wr_check,
    // Memory options
    input wire logic reduced_drive,
    input wire logic odt_enable,
    input wire logic [1:0] odt_sel,
    input wire logic [ROW_BITS-1:0] ext_mode_word,
    // Memory link
    input wire logic mem_cs_n,
    input wire logic mem_ras_n,
    input wire logic mem_cas_n,
    input wire logic mem_we_n,
    input wire logic [CLOCK_PAIRS-1:0] mem_clk_p,
    input wire logic [CLOCK_PAIRS-1:0] mem_clk_n
);
    // Read latency with the decoder in the path
    localparam int LAT = ddr2_cfg_pkg::READ_LAT_BASE
        + (ECC_ENABLE ? ddr2_cfg_pkg::ECC_EXTRA_LAT : 0);

    // Reset history on the link clock; it covers the link synchroniser,
    // so that link checks wait until the pins have left reset
    logic [4:0] lrst_hist_q;
    logic link_rst;
    always_ff @(posedge mem_half_rate_clock)
    begin
        lrst_hist_q <= {lrst_hist_q[3:0], rst};
    end
    assign link_rst = rst || lrst_hist_q != 5'h00;

    // ==========================================================
    // Local side
    property p_lat;
        @(posedge ref_clk) disable iff (rst)
        read_request |-> ##LAT read_data_valid;
    endproperty
    a_lat: assert property (p_lat) else $error("late valid");
    property p_stat;
        @(posedge ref_clk) disable iff (rst)
        read_data_valid |->
            ecc_status[3] == ecc_status[1] && ecc_status != 4'h5;
    endproperty
    a_stat: assert property (p_stat) else $error("bad status");
    property p_busy;
        @(posedge ref_clk) disable iff (rst) $rose(init) |=> busy;
    endproperty
    a_busy: assert property (p_busy) else $error("no busy");
    property p_opts;
        @(posedge ref_clk) disable iff (rst)
        1'b1 |=> {ext_mode_word[6], ext_mode_word[2:1]} ==
            {($past(odt_enable) ? $past(odt_sel) : 2'h0),
            $past(reduced_drive)};
    endproperty
    a_opts: assert property (p_opts) else $error("mode");
    property p_chk;
        @(posedge ref_clk) disable iff (rst)
        ECC_ENABLE |=> !(^{$past(wr_word), wr_check});
    endproperty
    a_chk: assert property (p_chk) else $error("bad check");

    // ==========================================================
    // Memory link
    sequence s_act;
        !mem_cs_n && !mem_ras_n;
    endsequence
    property p_cmd;
        @(posedge mem_half_rate_clock) disable iff (link_rst)
        !mem_cs_n |-> mem_we_n && !(mem_ras_n && mem_cas_n);
    endproperty
    a_cmd: assert property (p_cmd) else $error("bad command");
    property p_act;
        @(posedge mem_half_rate_clock) disable iff (link_rst)
        s_act |=> mem_ras_n;
    endproperty
    a_act: assert property (p_act) else $error("long strobe");
    property p_clk;
        @(posedge mem_half_rate_clock) disable iff (link_rst)
        mem_clk_n == ~mem_clk_p && mem_clk_p != $past(mem_clk_p);
    endproperty
    a_clk: assert property (p_clk) else $error("bad clock pair");
endmodule // ddr2_read_port_chk

bind ddr2_read_port ddr2_read_port_chk #(.DATA_WIDTH(DATA_WIDTH),
    .ROW_BITS(ROW_BITS), .CLOCK_PAIRS(CLOCK_PAIRS), .ECC_ENABLE(ECC_ENABLE))
chk (.ref_clk, .rst, .mem_half_rate_clock, .init, .read_request,
    .read_data_valid, .ecc_status, .busy, .wr_word, .wr_check, .reduced_drive,
    .odt_enable, .odt_sel, .ext_mode_word, .mem_cs_n, .mem_ras_n, .mem_cas_n,
    .mem_we_n, .mem_clk_p, .mem_clk_n);

// file: tb/ddr2_mem_model.sv
// Behavioural ECC memory module serving read bursts on the link
module ddr2_mem_model #(parameter int FW = 72, parameter int BURST = 4)
(
    // Link clock and reset
    input wire logic link_clk,
    input wire logic rst,
    // Commands, capture handshake and pacing
    input wire logic cs_n,
    input wire logic cas_n,
    input wire logic capture_ready,
    input wire logic slow,
    // Read words towards the controller
    output logic [FW-1:0] word,
    output logic word_valid
);
    logic [FW-1:0] store[$];
    int pending;
    int gap;

    // Words hold 64 data and 8 check bits, as an ECC module does
    task automatic load(input logic [FW-1:0] w);
        store.push_back(w);
    endtask

    // A read command frees one burst; a word holds until captured,
    // then the bus shows its inverse so stale data is never mistaken
    always @(posedge link_clk)
    begin
        if (rst)
        begin
            pending = 0;
            gap = 0;
            word_valid <= 1'b0;
            word <= '0;
        end
        else
        begin
            pending += (!cs_n && !cas_n) ? BURST : 0;
            gap -= (gap > 0) ? 1 : 0;
            if (word_valid && capture_ready)
            begin
                void'(store.pop_front());
                pending--;
                gap = slow ? 6 : 0;
                word_valid <= 1'b0;
                word <= ~word;
            end
            else if (!word_valid && gap == 0 && pending > 0
                && store.size() > 0)
            begin
                word <= store[0];
                word_valid <= 1'b1;
            end
        end
    end
endmodule // ddr2_mem_model

// file: tb/tb_ddr2_read_port.sv
// Self-checking bench for the DDR2 read port with and without ECC
module tb_ddr2_read_port;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LAT = ddr2_cfg_pkg::READ_LAT_BASE
        + ddr2_cfg_pkg::ECC_EXTRA_LAT;
    logic ref_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic init = 1'b0;
    logic read_request = 1'b0;
    logic reduced_drive = 1'b0;
    logic odt_enable = 1'b0;
    logic slow = 1'b1;
    logic [1:0] odt_sel = 2'h0;
    logic [26:0] start_addr = 27'h0;
    logic [63:0] wr_word = 64'h0;
    logic [63:0] read_data;
    logic [3:0] ecc_status;
    logic [7:0] wr_check;
    logic [13:0] ext_mode_word;
    logic [71:0] mem_rd_word;
    logic read_data_valid, busy, underrun, mem_odt;
    logic mem_cs_n, mem_cas_n, mem_rd_valid, capture_ready;
    logic plain_valid;
    logic [3:0] plain_st;
    logic [5:0] req_h = 6'h00;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    int req_q[$];
    int lat_q[$];
    logic [67:0] got_q[$];
    // Fault injected into each stored word and the status it must raise
    logic [71:0] fault[8] = '{72'h0, 72'h20, 72'h100_0000_0000, 72'h208,
        72'h4_0000_0000_0000_0000, 72'h8000_0000_0000_0000, 72'h0, 72'h0};
    logic [3:0] exp_st[8] = '{4'h0, 4'h1, 4'h4, 4'ha, 4'h1, 4'h4, 4'h0, 4'h0};

    // Local and link clocks of unrelated phase
    always #12.5 ref_clk = ~ref_clk;
    always #24 link_clk = ~link_clk;

    ddr2_read_port dut (.ref_clk, .rst, .mem_half_rate_clock(link_clk),
        .init, .start_addr, .read_request, .read_data, .read_data_valid,
        .ecc_status, .busy, .underrun, .wr_word, .wr_check, .reduced_drive,
        .odt_enable, .odt_sel, .ext_mode_word, .mem_cs_n, .mem_ras_n(),
        .mem_cas_n, .mem_we_n(), .mem_ba(), .mem_addr(), .mem_odt,
        .mem_clk_p(), .mem_clk_n(), .mem_rd_word, .mem_rd_valid,
        .capture_ready);
    ddr2_mem_model mdl (.link_clk, .rst, .cs_n(mem_cs_n), .cas_n(mem_cas_n),
        .capture_ready, .slow, .word(mem_rd_word), .word_valid(mem_rd_valid));
    // Second port without ECC, used for latency and status only
    ddr2_read_port #(.ECC_ENABLE(1'b0)) dut_plain (.ref_clk, .rst,
        .mem_half_rate_clock(link_clk), .init, .start_addr, .read_request,
        .read_data(), .read_data_valid(plain_valid), .ecc_status(plain_st),
        .busy(), .underrun(), .wr_word, .wr_check(), .reduced_drive,
        .odt_enable, .odt_sel, .ext_mode_word(), .mem_cs_n(), .mem_ras_n(),
        .mem_cas_n(), .mem_we_n(), .mem_ba(), .mem_addr(), .mem_odt(),
        .mem_clk_p(), .mem_clk_n(), .mem_rd_word, .mem_rd_valid(1'b0),
        .capture_ready());

    task automatic tick(input int n = 1);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic [63:0] pat(input int i);
        return 64'h0f1e_2d3c_4b5a_6978 * 64'(i + 1);
    endfunction
    // Waits, bounded, for busy to reach a level
    task automatic wait_busy(input logic lvl);
        for (int n = 0; n < 2000 && busy !== lvl; n++)
            tick();
        check(64'(busy), 64'(lvl));
    endtask
    // Requests n words back to back, then lets the pipeline drain
    task automatic read_words(input int n);
        read_request <= 1'b1;
        tick(n);
        read_request <= 1'b0;
        tick(LAT + 1);
    endtask

    // Records each returned word with its latency; cuts a hang short
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        req_h <= {req_h[4:0], read_request};
        // Valid must mirror the request history on every cycle
        if (!rst)
        begin
            check({plain_valid, plain_st}, {req_h[2], 4'h0});
            check(64'(read_data_valid), 64'(req_h[5]));
        end
        if (read_request)
            req_q.push_back(cyc);
        if (read_data_valid)
        begin
            got_q.push_back({ecc_status, read_data});
            lat_q.push_back(cyc - req_q.pop_front());
        end
        if (cyc == 20000)
        begin
            error_cnt++;
            conclude();
        end
    end

    // Main sequence
    initial
    begin
        tick(3);
        rst <= 1'b0;
        tick(2);
        check({busy, underrun, ecc_status, ext_mode_word}, 64'h0);
        for (int i = 0; i < 4; i++)
        begin
            reduced_drive <= i[0];
            odt_enable <= 1'b1;
            odt_sel <= 2'(i);
            tick(3);
            check(64'(ext_mode_word), {i[1],3'h0,i[0],i[0],1'b0});
        end
        check(64'(mem_odt), 64'h1);
        for (int i = 0; i < 8; i++)
        begin
            wr_word <= pat(i);
            tick(2);
            mdl.load({wr_check, pat(i)} ^ fault[i]);
        end
        start_addr <= 27'h40;
        init <= 1'b1;
        tick();
        init <= 1'b0;
        wait_busy(1'b1);
        wait_busy(1'b0);
        slow <= 1'b0;
        read_words(4);
        for (int n = 0; n < 2000 && mdl.store.size() != 0; n++)
            tick();
        tick(20);
        read_words(4);
        read_words(1);
        check(64'(underrun), 64'h1);
        check(64'(got_q.size()), 64'h9);
        for (int i = 0; i < 8; i++)
        begin
            check(64'(got_q[i][67:64]), 64'(exp_st[i]));
            check(64'(lat_q[i]), 64'(LAT));
            if (exp_st[i] != 4'ha)
                check(got_q[i][63:0], pat(i));
        end
        conclude();
    end
endmodule // tb_ddr2_read_port
